/* File: core/bus_fault_tester.sv */
// one-shot pull-down test of the inactive side of the pass switch
`timescale 1ns/100ps
module bus_fault_tester #(
	parameter int TEST_CYCLES = sensor_bus_pkg::FAULT_TEST_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic test_upstream,
	input wire logic sense_high,
	output logic pulldown_up,
	output logic pulldown_down,
	output logic busy,
	output logic done,
	output logic fault
);
	typedef enum logic [0:0] {IDLE, TESTING} tst_e;
	tst_e state_r, state_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic up_r, up_nxt, down_r, down_nxt, done_r, done_nxt, fault_r, fault_nxt;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		up_nxt = up_r;
		down_nxt = down_r;
		done_nxt = 1'b0;
		fault_nxt = fault_r;
		case (state_r)
			IDLE: begin
				if (start) begin
					state_nxt = TESTING;
					cnt_nxt = 16'(TEST_CYCLES - 1);
					up_nxt = test_upstream;
					down_nxt = ~test_upstream;
					fault_nxt = 1'b0;
				end
			end
			TESTING: begin
				// any high sample while sinking current counts as a fault
				if (sense_high) begin
					fault_nxt = 1'b1;
				end
				if (cnt_r == 16'h0000) begin
					state_nxt = IDLE;
					up_nxt = 1'b0;
					down_nxt = 1'b0;
					done_nxt = 1'b1;
				end else begin
					cnt_nxt = cnt_r - 16'h0001;
				end
			end
			default: begin
				state_nxt = IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= IDLE;
			cnt_r <= 16'h0000;
			up_r <= 1'b0;
			down_r <= 1'b0;
			done_r <= 1'b0;
			fault_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			up_r <= up_nxt;
			down_r <= down_nxt;
			done_r <= done_nxt;
			fault_r <= fault_nxt;
		end
	end

	assign pulldown_up = up_r;
	assign pulldown_down = down_r;
	assign busy = (state_r == TESTING);
	assign done = done_r;
	assign fault = fault_r;
endmodule

/* File: core/bus_slave_reverse_init_and_fault.sv */
// command interpreter of a daisy-chained sensor bus slave with apb status
//
// Functional notes
// - group bits unused, reported as zero
// - valid reverse init loads target address
// - program-enable bit allows or refuses nvm address
// - stored permanent address makes program-enable ignored
// - reverse init answered only as long word
// - response: address, zeros, fault, flags, target, check
// - response travels during the next command
// - corrupted frame gets no response next frame
// - switch request runs one pull-down fault test
// - downstream tested on forward, upstream on reverse
// - close switch after test only without fault
// - test runs whether or not nvm programmed
// - looped chain skips the fault test
// - global init: address zero, switch open, flags kept
// - address zero executes commands but stays silent
// - global init blocks re-init until clear
// - accepted reverse init blocks re-init until clear
// - switch request closes switch unless the fault test fails, and assigns address
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module bus_slave_reverse_init_and_fault #(
	parameter int FAULT_TEST_CYCLES = sensor_bus_pkg::FAULT_TEST_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic rx_long,
	input wire logic [19:0] rx_word,
	input wire logic fault_sense_high,
	input wire logic [3:0] io_levels,
	input wire logic undervoltage,
	output logic [19:0] tx_word,
	output logic tx_long,
	output logic tx_drive,
	output logic switch_closed,
	output logic pulldown_upstream,
	output logic pulldown_downstream,
	output logic drive_output_pin,
	output logic nvm_program_enable,
	output logic bus_fault_flag,
	output logic [3:0] device_address
);
	logic [3:0] addr_r, addr_nxt;
	logic init_r, init_nxt, global_r, global_nxt;
	logic nv_r, nv_nxt, bs_r, bs_nxt, switch_r, switch_nxt, bf_r, bf_nxt, lo_r, lo_nxt;
	logic [19:0] resp_r, resp_nxt;
	logic [15:0] resp_body_nxt;
	logic resp_long_r, resp_long_nxt, resp_drive_r, resp_drive_nxt;
	logic resp_is_init_r, resp_is_init_nxt;
	logic loop_mode_r, loop_mode_nxt, nvm_stored_r, nvm_stored_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;

	logic [15:0] rx_body;
	logic [3:0] rx_crc, rx_calc, tx_calc;
	logic [3:0] rx_cmd, rx_addr, rx_target;
	logic [7:0] rx_data;
	logic rx_ok, test_start, test_up, test_busy, test_done, test_fault;
	// pads as sized constants so the response bodies stay exactly 16 bits
	localparam logic [2:0] RESP_PAD_W = sensor_bus_pkg::RESP_PAD;
	localparam logic [3:0] RESP_HI_PAD_W = sensor_bus_pkg::RESP_HI_PAD;

	// short frames are zero-extended so one checker serves both sizes
	assign rx_body = rx_long ? rx_word[19:sensor_bus_pkg::FRM_BODY_LSB]
		: {sensor_bus_pkg::SHORT_HI, rx_word[sensor_bus_pkg::FRM_BODY_LSB +: sensor_bus_pkg::SHORT_BODY_W]};
	assign rx_crc = rx_word[sensor_bus_pkg::FRM_CRC_LSB +: 4];
	assign rx_cmd = rx_body[sensor_bus_pkg::BODY_CMD_LSB +: 4];
	assign rx_addr = rx_body[sensor_bus_pkg::BODY_ADDR_LSB +: 4];
	assign rx_data = rx_body[sensor_bus_pkg::BODY_DATA_LSB +: 8];
	assign rx_target = rx_data[sensor_bus_pkg::DAT_TARGET_LSB +: 4];
	assign rx_ok = (rx_calc == rx_crc);

	frame_check_gen #(.WIDTH(16)) rx_check (
		.body(rx_body),
		.check(rx_calc)
	);

	frame_check_gen #(.WIDTH(16)) tx_check (
		.body(resp_body_nxt),
		.check(tx_calc)
	);

	bus_fault_tester #(.TEST_CYCLES(FAULT_TEST_CYCLES)) fault_test (
		.pclk(pclk),
		.presetn(presetn),
		.start(test_start),
		.test_upstream(test_up),
		.sense_high(fault_sense_high),
		.pulldown_up(pulldown_upstream),
		.pulldown_down(pulldown_downstream),
		.busy(test_busy),
		.done(test_done),
		.fault(test_fault)
	);

	assign resp_nxt = {resp_body_nxt, tx_calc};

	// command decode and response preparation
	always_comb begin
		addr_nxt = addr_r;
		init_nxt = init_r;
		global_nxt = global_r;
		nv_nxt = nv_r;
		bs_nxt = bs_r;
		switch_nxt = switch_r;
		bf_nxt = bf_r;
		lo_nxt = lo_r;
		resp_body_nxt = resp_r[19:sensor_bus_pkg::FRM_BODY_LSB];
		resp_long_nxt = resp_long_r;
		resp_drive_nxt = resp_drive_r;
		resp_is_init_nxt = resp_is_init_r;
		test_start = 1'b0;
		test_up = 1'b0;
		if (test_done) begin
			bf_nxt = test_fault;
			switch_nxt = ~test_fault;
			// a still-pending init response picks up the late fault result
			if (resp_is_init_r) begin
				resp_body_nxt[sensor_bus_pkg::RESP_BF_BIT] = test_fault;
			end
		end
		if (rx_valid) begin
			// silence unless this frame earns an answer
			resp_drive_nxt = 1'b0;
			resp_is_init_nxt = 1'b0;
			if (rx_ok) begin
				case (rx_cmd)
					sensor_bus_pkg::CMD_REV_INIT, sensor_bus_pkg::CMD_FWD_INIT: begin
						// short init words and repeats after acceptance are ignored
						// the cycle that ends a test is no longer busy, so test_done is checked too and its fault result is never lost
						if (rx_long && !init_r && !global_r && !test_busy && !test_done) begin
							if (rx_addr == sensor_bus_pkg::GLOBAL_ADDR
									&& rx_target == sensor_bus_pkg::GLOBAL_ADDR) begin
								addr_nxt = sensor_bus_pkg::GLOBAL_ADDR;
								switch_nxt = 1'b0;
								init_nxt = 1'b1;
								global_nxt = 1'b1;
							end else if (rx_addr == sensor_bus_pkg::GLOBAL_ADDR
									|| rx_addr == rx_target) begin
								addr_nxt = rx_target;
								init_nxt = 1'b1;
								// a stored permanent address locks out programming
								nv_nxt = rx_data[sensor_bus_pkg::DAT_NV_BIT] & ~nvm_stored_r;
								bs_nxt = rx_data[sensor_bus_pkg::DAT_BS_BIT];
								bf_nxt = 1'b0;
								if (rx_data[sensor_bus_pkg::DAT_BS_BIT]) begin
									// both sides live in a loop, so a pull-down proves nothing
									if (loop_mode_r) begin
										switch_nxt = 1'b1;
									end else begin
										test_start = 1'b1;
										test_up = (rx_cmd == sensor_bus_pkg::CMD_REV_INIT);
									end
								end
								resp_body_nxt = {addr_nxt, RESP_PAD_W, 1'b0,
									nv_nxt, bs_nxt, sensor_bus_pkg::GROUP_ZERO, rx_target};
								resp_long_nxt = 1'b1;
								resp_drive_nxt = (rx_addr != sensor_bus_pkg::GLOBAL_ADDR);
								resp_is_init_nxt = 1'b1;
							end
						end
					end
					sensor_bus_pkg::CMD_CLEAR: begin
						init_nxt = 1'b0;
						global_nxt = 1'b0;
						lo_nxt = 1'b0;
						nv_nxt = 1'b0;
						bs_nxt = 1'b0;
					end
					sensor_bus_pkg::CMD_SET_OUT, sensor_bus_pkg::CMD_CLR_OUT: begin
						if (init_r && rx_addr == addr_r) begin
							lo_nxt = (rx_cmd == sensor_bus_pkg::CMD_SET_OUT);
							resp_body_nxt = rx_long
								? {addr_r, RESP_HI_PAD_W, nv_r, undervoltage, lo_nxt, switch_r, io_levels}
								: {sensor_bus_pkg::SHORT_HI, nv_r, undervoltage, lo_nxt, switch_r, io_levels};
							resp_long_nxt = rx_long;
							// address zero acts but keeps the bus quiet
							resp_drive_nxt = (addr_r != sensor_bus_pkg::GLOBAL_ADDR);
						end
					end
					default: begin
						resp_drive_nxt = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_r <= 4'h0;
			init_r <= 1'b0;
			global_r <= 1'b0;
			nv_r <= 1'b0;
			bs_r <= 1'b0;
			switch_r <= 1'b0;
			bf_r <= 1'b0;
			lo_r <= 1'b0;
			resp_r <= 20'h00000;
			resp_long_r <= 1'b0;
			resp_drive_r <= 1'b0;
			resp_is_init_r <= 1'b0;
		end else begin
			addr_r <= addr_nxt;
			init_r <= init_nxt;
			global_r <= global_nxt;
			nv_r <= nv_nxt;
			bs_r <= bs_nxt;
			switch_r <= switch_nxt;
			bf_r <= bf_nxt;
			lo_r <= lo_nxt;
			resp_r <= resp_nxt;
			resp_long_r <= resp_long_nxt;
			resp_drive_r <= resp_drive_nxt;
			resp_is_init_r <= resp_is_init_nxt;
		end
	end

	// apb slave: no wait state; read data is registered in the setup cycle so it comes from a flop
	always_comb begin
		logic setup;
		logic mapped;
		setup = psel & ~penable;
		mapped = (paddr == sensor_bus_pkg::REG_CTRL) || (paddr == sensor_bus_pkg::REG_STATUS);
		loop_mode_nxt = loop_mode_r;
		nvm_stored_nxt = nvm_stored_r;
		pready_nxt = setup;
		pslverr_nxt = setup & ~mapped;
		prdata_nxt = prdata_r;
		if (setup) begin
			prdata_nxt = 32'h00000000;
			if (!pwrite && paddr == sensor_bus_pkg::REG_CTRL) begin
				prdata_nxt[sensor_bus_pkg::CTRL_LOOP_BIT] = loop_mode_r;
				prdata_nxt[sensor_bus_pkg::CTRL_NVSTORED_BIT] = nvm_stored_r;
			end else if (!pwrite && paddr == sensor_bus_pkg::REG_STATUS) begin
				prdata_nxt[sensor_bus_pkg::ST_ADDR_LSB +: 4] = addr_r;
				prdata_nxt[sensor_bus_pkg::ST_INIT_BIT] = init_r;
				prdata_nxt[sensor_bus_pkg::ST_GLOBAL_BIT] = global_r;
				prdata_nxt[sensor_bus_pkg::ST_NV_BIT] = nv_r;
				prdata_nxt[sensor_bus_pkg::ST_BS_BIT] = bs_r;
				prdata_nxt[sensor_bus_pkg::ST_SWITCH_BIT] = switch_r;
				prdata_nxt[sensor_bus_pkg::ST_FAULT_BIT] = bf_r;
				prdata_nxt[sensor_bus_pkg::ST_BUSY_BIT] = test_busy;
				prdata_nxt[sensor_bus_pkg::ST_OUT_BIT] = lo_r;
			end
		end
		if (psel && penable && pready_r && pwrite && paddr == sensor_bus_pkg::REG_CTRL) begin
			loop_mode_nxt = pwdata[sensor_bus_pkg::CTRL_LOOP_BIT];
			nvm_stored_nxt = pwdata[sensor_bus_pkg::CTRL_NVSTORED_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_mode_r <= 1'b0;
			nvm_stored_r <= 1'b0;
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			loop_mode_r <= loop_mode_nxt;
			nvm_stored_r <= nvm_stored_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign tx_word = resp_r;
	assign tx_long = resp_long_r;
	assign tx_drive = resp_drive_r;
	assign switch_closed = switch_r;
	assign drive_output_pin = lo_r;
	assign nvm_program_enable = nv_r;
	assign bus_fault_flag = bf_r;
	assign device_address = addr_r;
endmodule

/* File: core/frame_check_gen.sv */
// four-bit check field over a frame body, msb first
`timescale 1ns/100ps
module frame_check_gen #(
	parameter int WIDTH = 16
) (
	input wire logic [WIDTH-1:0] body,
	output logic [3:0] check
);
	always_comb begin
		logic [3:0] c;
		logic fb;
		c = sensor_bus_pkg::CRC_SEED;
		fb = 1'b0;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			fb = c[3] ^ body[i];
			c = {c[2:0], 1'b0} ^ (fb ? sensor_bus_pkg::CRC_POLY : 4'h0);
		end
		check = c;
	end
endmodule

/* File: core/sensor_bus_pkg.sv */
// constants shared by the sensor bus slave command logic
package sensor_bus_pkg;
	// timing
	localparam int CLK_HZ = 50_000_000;
	localparam int FAULT_TEST_US = 200;
	localparam int FAULT_TEST_CYCLES = FAULT_TEST_US * (CLK_HZ / 1_000_000);
	// command opcodes
	localparam logic [3:0] CMD_REV_INIT = 4'hf;
	localparam logic [3:0] CMD_FWD_INIT = 4'he;
	localparam logic [3:0] CMD_CLEAR = 4'ha;
	localparam logic [3:0] CMD_NVM = 4'h9;
	localparam logic [3:0] CMD_SET_OUT = 4'hd;
	localparam logic [3:0] CMD_CLR_OUT = 4'hc;
	// frame layout: long = data8 addr4 cmd4 check4, short = addr4 cmd4 check4
	localparam int FRM_CRC_LSB = 0;
	localparam int FRM_BODY_LSB = 4;
	localparam int BODY_CMD_LSB = 0;
	localparam int BODY_ADDR_LSB = 4;
	localparam int BODY_DATA_LSB = 8;
	localparam int SHORT_BODY_W = 8;
	// data byte of an initialization command
	localparam int DAT_TARGET_LSB = 0;
	localparam int DAT_GROUP_LSB = 4;
	localparam int DAT_BS_BIT = 6;
	localparam int DAT_NV_BIT = 7;
	// position of the fault flag inside a response body
	localparam int RESP_BF_BIT = 8;
	// check field generator, then fixed address and padding values
	localparam logic [3:0] CRC_POLY = 4'h3;
	localparam logic [3:0] CRC_SEED = 4'h0;
	localparam logic [3:0] GLOBAL_ADDR = 4'h0;
	localparam logic [1:0] GROUP_ZERO = 2'h0;
	localparam logic [2:0] RESP_PAD = 3'h0;
	localparam logic [3:0] RESP_HI_PAD = 4'h0;
	localparam logic [7:0] SHORT_HI = 8'h00;
	// apb map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam int CTRL_LOOP_BIT = 0;
	localparam int CTRL_NVSTORED_BIT = 1;
	localparam int ST_ADDR_LSB = 0;
	localparam int ST_INIT_BIT = 4;
	localparam int ST_GLOBAL_BIT = 5;
	localparam int ST_NV_BIT = 6;
	localparam int ST_BS_BIT = 7;
	localparam int ST_SWITCH_BIT = 8;
	localparam int ST_FAULT_BIT = 9;
	localparam int ST_BUSY_BIT = 10;
	localparam int ST_OUT_BIT = 11;
endpackage

/* File: sim/bus_slave_reverse_init_and_fault_sva.sv */
// concurrent checks on the command and fault test outputs
`timescale 1ns/100ps
module bus_slave_checker #(
	parameter int FAULT_TEST_CYCLES = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic rx_valid,
	input wire logic rx_long,
	input wire logic [19:0] rx_word,
	input wire logic [19:0] tx_word,
	input wire logic tx_long,
	input wire logic tx_drive,
	input wire logic switch_closed,
	input wire logic pulldown_upstream,
	input wire logic pulldown_downstream,
	input wire logic bus_fault_flag,
	input wire logic [3:0] device_address
);
	logic rev_cmd;
	logic pd_any;
	int cnt_r;
	int cnt_nxt;
	assign rev_cmd = rx_valid && rx_long && rx_word[7:4] == sensor_bus_pkg::CMD_REV_INIT;
	assign pd_any = pulldown_upstream || pulldown_downstream;
	always_comb begin
		cnt_nxt = pd_any ? cnt_r + 1 : 0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_group_zero: assert property (rev_cmd |=> !tx_drive || tx_word[9:8] == 2'h0)
		else $error("group bits not zero in response");
	chk_init_long: assert property (rev_cmd |=> !tx_drive || tx_long)
		else $error("init response not long");
	chk_resp_fields: assert property (rev_cmd |=> !tx_drive || (tx_word[19:16] == $past(rx_word[11:8])
		&& tx_word[15:13] == 3'h0 && tx_word[7:4] == $past(rx_word[15:12])))
		else $error("init response fields wrong");
	chk_addr_load: assert property (rev_cmd |=> !tx_drive || device_address == $past(rx_word[15:12]))
		else $error("address not loaded");
	chk_one_side: assert property (!(pulldown_upstream && pulldown_downstream))
		else $error("both sides pulled down");
	chk_up_cause: assert property ($rose(pulldown_upstream) |-> $past(rev_cmd))
		else $error("upstream test without reverse init");
	chk_down_cause: assert property ($rose(pulldown_downstream)
		|-> $past(rx_valid && rx_word[7:4] == sensor_bus_pkg::CMD_FWD_INIT))
		else $error("downstream test without forward init");
	chk_close_clean: assert property ($rose(switch_closed) |-> !bus_fault_flag && !pd_any)
		else $error("switch closed with fault or test running");
	chk_test_len: assert property (!pd_any && cnt_r != 0
		|-> cnt_r >= FAULT_TEST_CYCLES && cnt_r <= FAULT_TEST_CYCLES + 2)
		else $error("fault test length wrong");
	chk_zero_silent: assert property (rx_valid && rx_word[11:8] == sensor_bus_pkg::GLOBAL_ADDR
		|=> !tx_drive)
		else $error("response at address zero");
	chk_global_quiet: assert property (rev_cmd && rx_word[15:8] == 8'h00 && !pd_any
		|=> !pulldown_upstream)
		else $error("global init started a test");
endmodule
bind bus_slave_reverse_init_and_fault bus_slave_checker #(.FAULT_TEST_CYCLES(FAULT_TEST_CYCLES)) chk_i (
	.pclk(pclk), .presetn(presetn), .rx_valid(rx_valid), .rx_long(rx_long), .rx_word(rx_word),
	.tx_word(tx_word), .tx_long(tx_long), .tx_drive(tx_drive), .switch_closed(switch_closed),
	.pulldown_upstream(pulldown_upstream), .pulldown_downstream(pulldown_downstream),
	.bus_fault_flag(bus_fault_flag), .device_address(device_address));

/* File: sim/frame_master_model.sv */
// bus master model that sends command frames with a computed check field
`timescale 1ns/100ps
module frame_master_model (
	input wire logic pclk,
	output logic rx_valid,
	output logic rx_long,
	output logic [19:0] rx_word
);
	initial begin
		rx_valid = 1'b0;
		rx_long = 1'b0;
		rx_word = 20'h5a5a5;
	end
	// msb-first lfsr written apart from the device's own generator
	function automatic logic [3:0] crc4(input logic [15:0] body);
		logic [3:0] c;
		logic fb;
		c = sensor_bus_pkg::CRC_SEED;
		for (int i = 15; i >= 0; i--) begin
			fb = c[3] ^ body[i];
			c = {c[2:0], 1'b0} ^ (fb ? sensor_bus_pkg::CRC_POLY : 4'h0);
		end
		return c;
	endfunction
	// short frames come with body[15:8] zero, so both sizes share one path
	task automatic send(input logic lng, input logic [15:0] body, input logic bad);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_long <= lng;
		rx_word <= {body, crc4(body) ^ {3'h0, bad}};
		@(posedge pclk);
		rx_valid <= 1'b0;
		// no stale frame left on the lines between frames
		rx_word <= ~{body, crc4(body)};
	endtask
endmodule

/* File: sim/tb_bus_slave_reverse_init_and_fault.sv */
// testbench: apb and frame sequences with expected values
`timescale 1ns/100ps
module tb_bus_slave_reverse_init_and_fault;
	localparam int FT = 8;
	localparam logic [3:0] REV = sensor_bus_pkg::CMD_REV_INIT;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic rx_valid, rx_long, fault_sense_high, undervoltage, tx_long, tx_drive, switch_closed;
	logic pu, pd, drive_output_pin, nvm_program_enable, bus_fault_flag;
	logic [19:0] rx_word, tx_word;
	logic [3:0] io_levels, device_address;
	int err_count = 0;
	int checks = 0;
	bus_slave_reverse_init_and_fault #(.FAULT_TEST_CYCLES(FT)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_long(rx_long), .rx_word(rx_word),
		.fault_sense_high(fault_sense_high), .io_levels(io_levels), .undervoltage(undervoltage),
		.tx_word(tx_word), .tx_long(tx_long), .tx_drive(tx_drive), .switch_closed(switch_closed),
		.pulldown_upstream(pu), .pulldown_downstream(pd), .drive_output_pin(drive_output_pin),
		.nvm_program_enable(nvm_program_enable), .bus_fault_flag(bus_fault_flag),
		.device_address(device_address));
	frame_master_model master (.pclk(pclk), .rx_valid(rx_valid), .rx_long(rx_long), .rx_word(rx_word));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic test_done;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// wait for pready without assuming the answer latency; if pready never comes, only the watchdog ends the wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(negedge pclk);
		while (pready !== 1'b1) begin
			@(negedge pclk);
		end
		// settled mid-cycle, these stand until the completing rising edge
		rd = prdata;
		er = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic frame(input logic lng, input logic [3:0] cmd, input logic [3:0] a, input logic [7:0] d,
		input logic bad);
		master.send(lng, {d, a, cmd}, bad);
		@(negedge pclk);
	endtask
	task automatic wait_test;
		@(negedge pclk);
		while (pu || pd) begin
			@(negedge pclk);
		end
		repeat (2) @(negedge pclk);
	endtask
	task automatic do_reset;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		err_count++;
		test_done;
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		fault_sense_high = 1'b0;
		io_levels = 4'h9;
		undervoltage = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, sensor_bus_pkg::REG_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk(32'(er), 32'h1);
		frame(1'b1, REV, 4'h5, 8'hf5, 1'b1);
		chk(32'(tx_drive), 32'h0);
		chk(32'(device_address), 32'h0);
		// group bits sent as ones must come back as zero
		frame(1'b1, REV, 4'h5, 8'hf5, 1'b0);
		chk(32'(tx_drive), 32'h1);
		chk(32'(tx_long), 32'h1);
		chk(32'(tx_word), 32'({16'h50c5, master.crc4(16'h50c5)}));
		chk(32'(device_address), 32'h5);
		chk(32'(nvm_program_enable), 32'h1);
		chk(32'(pu), 32'h1);
		wait_test;
		chk(32'(switch_closed), 32'h1);
		frame(1'b1, REV, 4'h6, 8'h06, 1'b0);
		chk(32'(tx_drive), 32'h0);
		chk(32'(device_address), 32'h5);
		frame(1'b0, sensor_bus_pkg::CMD_SET_OUT, 4'h5, 8'h00, 1'b0);
		chk(32'(drive_output_pin), 32'h1);
		chk(32'(tx_long), 32'h0);
		chk(32'(tx_word), 32'({16'h00b9, master.crc4(16'h00b9)}));
		frame(1'b0, sensor_bus_pkg::CMD_CLEAR, 4'h5, 8'h00, 1'b0);
		frame(1'b1, REV, 4'h0, 8'hc0, 1'b0);
		chk(32'(device_address), 32'h0);
		chk(32'(nvm_program_enable), 32'h0);
		chk(32'(pu), 32'h0);
		chk(32'(switch_closed), 32'h0);
		frame(1'b0, sensor_bus_pkg::CMD_SET_OUT, 4'h0, 8'h00, 1'b0);
		chk(32'(drive_output_pin), 32'h1);
		chk(32'(tx_drive), 32'h0);
		frame(1'b0, sensor_bus_pkg::CMD_CLR_OUT, 4'h0, 8'h00, 1'b0);
		chk(32'(drive_output_pin), 32'h0);
		chk(32'(tx_drive), 32'h0);
		frame(1'b1, REV, 4'h7, 8'h07, 1'b0);
		chk(32'(device_address), 32'h0);
		// permanent address held: program enable ignored, test still runs
		do_reset;
		apb(1'b1, sensor_bus_pkg::REG_CTRL, 32'h2);
		fault_sense_high <= 1'b1;
		frame(1'b1, sensor_bus_pkg::CMD_FWD_INIT, 4'h3, 8'hc3, 1'b0);
		chk(32'(pd), 32'h1);
		chk(32'(nvm_program_enable), 32'h0);
		wait_test;
		chk(32'(bus_fault_flag), 32'h1);
		chk(32'(switch_closed), 32'h0);
		apb(1'b0, sensor_bus_pkg::REG_STATUS, 32'h0);
		fault_sense_high <= 1'b0;
		chk(32'(rd[sensor_bus_pkg::ST_FAULT_BIT]), 32'h1);
		// looped chain closes without a test
		do_reset;
		apb(1'b1, sensor_bus_pkg::REG_CTRL, 32'h1);
		frame(1'b1, REV, 4'h0, 8'h42, 1'b0);
		chk(32'(pu), 32'h0);
		chk(32'(device_address), 32'h2);
		repeat (3) @(negedge pclk);
		chk(32'(switch_closed), 32'h1);
		test_done;
	end
endmodule
